/* tsa_core.sv */
module tsa_core #(
	parameter int CONV_PERIOD_CYC_P = tsa_pkg::CONV_PERIOD_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	input  wire logic        adc_done_in,
	input  wire logic [11:0] adc_data_in,
	output logic             sda_out,
	output logic             sda_oe_n_out,
	output logic             adc_start_out,
	output logic             adc_power_out,
	output logic             temp_alert_output_out
);

	localparam int TICK_W = $clog2(CONV_PERIOD_CYC_P);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	logic                        link_rst_ff;
	logic                        frame_rst_ff;
	logic [tsa_pkg::SY_N-1:0]    raw_w;
	logic [tsa_pkg::SY_N-1:0]    sy1_ff;
	logic [tsa_pkg::SY_N-1:0]    sy2_ff;
	logic [tsa_pkg::SY_N-1:0]    sy3_ff;
	logic [tsa_pkg::SY_N-1:0]    filt_ff;
	logic [tsa_pkg::SY_N-1:0]    prev_ff;
	logic                        bus_start;
	logic                        bus_stop;
	logic                        ptr_ev;
	logic                        wr_ev;
	logic                        rd_ev;
	logic                        drive_low;
	logic [7:0]                  ptr_byte;
	logic                        ptr_tog;
	tsa_pkg::tsa_wbyte_t         wr_byte;
	logic                        wr_tog;
	logic                        rd_tog;
	logic [tsa_pkg::PTR_W-1:0]   pointer_ff;
	tsa_pkg::tsa_cfg_t           cfg_ff;
	logic [15:0]                 hysteresis_limit_ff;
	logic [15:0]                 overtemp_limit_ff;
	logic [7:0]                  wr_msb_ff;
	logic [15:0]                 temp_ff;
	logic [15:0]                 rd_word_ff;
	logic                        sleep;
	logic [TICK_W-1:0]           tick_cnt_ff;
	logic                        tick;
	logic                        oneshot_pend_ff;
	logic                        oneshot_set;
	tsa_pkg::tsa_conv_st_t       conv_st_ff;
	logic                        conv_go;
	logic                        conv_done;
	logic [15:0]                 new_res;
	logic                        over_hit;
	logic                        under_hyst;
	logic [2:0]                  fault_cnt_ff;
	logic [2:0]                  fault_need;
	logic                        fault_hit;
	logic                        alert_ff;
	logic                        armed_ff;
	logic                        set_int;
	logic                        alert_pin_ff;

	// ----------------------------------------------------------------
	// Link-side slave, clocked by the serial clock
	// ----------------------------------------------------------------
	// Kept outside the sleep logic so shutdown never silences it
	tsa_link u_link (
		.scl_in            (scl_in),
		.sda_in            (sda_in),
		.frame_rst_in      (frame_rst_ff),
		.link_rst_in       (link_rst_ff),
		.slave_addr_in     (tsa_pkg::SLAVE_ADDR_DEF),
		.rd_word_in        (rd_word_ff),
		.sda_drive_low_out (drive_low),
		.ptr_byte_out      (ptr_byte),
		.ptr_tog_out       (ptr_tog),
		.wr_byte_out       (wr_byte),
		.wr_tog_out        (wr_tog),
		.rd_tog_out        (rd_tog)
	);

	// Open-drain data line: only ever pulled low
	assign sda_out      = 1'b0;
	assign sda_oe_n_out = ~drive_low;

	// ----------------------------------------------------------------
	// Crossing into the system clock
	// ----------------------------------------------------------------
	assign raw_w[tsa_pkg::SY_SCL] = scl_in;
	assign raw_w[tsa_pkg::SY_SDA] = sda_in;
	assign raw_w[tsa_pkg::SY_PTR] = ptr_tog;
	assign raw_w[tsa_pkg::SY_WR]  = wr_tog;
	assign raw_w[tsa_pkg::SY_RD]  = rd_tog;

	// Three stages; a level is accepted once stages two and three agree
	for (genvar g = 0; g < tsa_pkg::SY_N; g++) begin : g_sync
		always_ff @(posedge clk_in) begin
			if (srst_in) begin
				sy1_ff[g]  <= tsa_pkg::SY_RST[g];
				sy2_ff[g]  <= tsa_pkg::SY_RST[g];
				sy3_ff[g]  <= tsa_pkg::SY_RST[g];
				filt_ff[g] <= tsa_pkg::SY_RST[g];
				prev_ff[g] <= tsa_pkg::SY_RST[g];
			end else begin
				sy1_ff[g] <= raw_w[g];
				sy2_ff[g] <= sy1_ff[g];
				sy3_ff[g] <= sy2_ff[g];
				if (sy2_ff[g] == sy3_ff[g])
					filt_ff[g] <= sy3_ff[g];
				prev_ff[g] <= filt_ff[g];
			end
		end
	end

	// Start and stop are data edges while the clock stays high
	assign bus_start = filt_ff[tsa_pkg::SY_SCL] & prev_ff[tsa_pkg::SY_SCL]
	                 & ~filt_ff[tsa_pkg::SY_SDA] & prev_ff[tsa_pkg::SY_SDA];
	assign bus_stop  = filt_ff[tsa_pkg::SY_SCL] & prev_ff[tsa_pkg::SY_SCL]
	                 & filt_ff[tsa_pkg::SY_SDA] & ~prev_ff[tsa_pkg::SY_SDA];
	assign ptr_ev    = filt_ff[tsa_pkg::SY_PTR] ^ prev_ff[tsa_pkg::SY_PTR];
	assign wr_ev     = filt_ff[tsa_pkg::SY_WR] ^ prev_ff[tsa_pkg::SY_WR];
	assign rd_ev     = filt_ff[tsa_pkg::SY_RD] ^ prev_ff[tsa_pkg::SY_RD];

	// Frame reset holds the link idle from start/stop until the clock falls
	always_ff @(posedge clk_in) begin
		link_rst_ff <= srst_in;
		if (srst_in || bus_start || bus_stop)
			frame_rst_ff <= 1'b1;
		else if (!filt_ff[tsa_pkg::SY_SCL] && !bus_stop)
			frame_rst_ff <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	// Pointer: only the low bits matter, write-only
	always_ff @(posedge clk_in) begin
		if (srst_in)
			pointer_ff <= tsa_pkg::PTR_TEMP;
		else if (ptr_ev)
			pointer_ff <= ptr_byte[tsa_pkg::PTR_W-1:0];
	end

	// Limits commit on their second byte so the pair changes together
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			cfg_ff              <= tsa_pkg::CFG_RST;
			hysteresis_limit_ff <= tsa_pkg::HYST_RST;
			overtemp_limit_ff   <= tsa_pkg::OVER_RST;
			wr_msb_ff           <= '0;
		end else if (wr_ev) begin
			if (!wr_byte.second)
				wr_msb_ff <= wr_byte.data;
			unique case (pointer_ff)
				tsa_pkg::PTR_CFG: begin
					if (!wr_byte.second)
						cfg_ff <= wr_byte.data & tsa_pkg::CFG_WR_MASK;
				end
				tsa_pkg::PTR_HYST: begin
					if (wr_byte.second)
						hysteresis_limit_ff <= {wr_msb_ff, wr_byte.data};
				end
				tsa_pkg::PTR_OVER: begin
					if (wr_byte.second)
						overtemp_limit_ff <= {wr_msb_ff, wr_byte.data};
				end
				default: begin
				end
			endcase
		end
	end

	// Written value is discarded; only the act of writing counts
	assign oneshot_set = wr_ev && !wr_byte.second && pointer_ff == tsa_pkg::PTR_ONESHOT && sleep;

	// ----------------------------------------------------------------
	// Read snapshot
	// ----------------------------------------------------------------
	// Whole word captured at address time so both bytes match
	always_ff @(posedge clk_in) begin
		if (srst_in)
			rd_word_ff <= '0;
		else if (rd_ev) begin
			unique case (pointer_ff)
				tsa_pkg::PTR_TEMP: rd_word_ff <= temp_ff;
				tsa_pkg::PTR_CFG:  rd_word_ff <= {cfg_ff, tsa_pkg::RD_PAD};
				tsa_pkg::PTR_HYST: rd_word_ff <= hysteresis_limit_ff;
				tsa_pkg::PTR_OVER: rd_word_ff <= overtemp_limit_ff;
				default:           rd_word_ff <= '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Conversion scheduling
	// ----------------------------------------------------------------
	// One-shot mode bit is treated as a second way to sleep
	assign sleep = cfg_ff.shutdown | cfg_ff.oneshot_mode;
	assign tick  = tick_cnt_ff == TICK_W'(CONV_PERIOD_CYC_P - 1);

	// Period counter runs only when awake; reads never touch it
	always_ff @(posedge clk_in) begin
		if (srst_in || sleep)
			tick_cnt_ff <= '0;
		else if (tick)
			tick_cnt_ff <= '0;
		else
			tick_cnt_ff <= tick_cnt_ff + TICK_W'(1);
	end

	assign conv_go   = conv_st_ff == tsa_pkg::CV_IDLE && ((tick && !sleep) || oneshot_pend_ff);
	assign conv_done = conv_st_ff == tsa_pkg::CV_BUSY && adc_done_in;

	// Pending one-shot: a new request wins over the clear
	always_ff @(posedge clk_in) begin
		if (srst_in)
			oneshot_pend_ff <= 1'b0;
		else
			oneshot_pend_ff <= oneshot_set | (oneshot_pend_ff & ~conv_go);
	end

	// Converter sequencer; a tick during a busy conversion is skipped
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			conv_st_ff    <= tsa_pkg::CV_IDLE;
			adc_start_out <= 1'b0;
		end else begin
			adc_start_out <= conv_go;
			unique case (conv_st_ff)
				tsa_pkg::CV_IDLE: if (conv_go) conv_st_ff <= tsa_pkg::CV_BUSY;
				tsa_pkg::CV_BUSY: if (adc_done_in) conv_st_ff <= tsa_pkg::CV_IDLE;
			endcase
		end
	end

	// Power stays up while awake or converting, then drops back
	always_ff @(posedge clk_in) begin
		if (srst_in)
			adc_power_out <= 1'b0;
		else
			adc_power_out <= !sleep || oneshot_pend_ff || conv_st_ff == tsa_pkg::CV_BUSY;
	end

	// ----------------------------------------------------------------
	// Result store
	// ----------------------------------------------------------------
	assign new_res = {adc_data_in, tsa_pkg::RES_PAD};

	always_ff @(posedge clk_in) begin
		if (srst_in)
			temp_ff <= tsa_pkg::TEMP_RST;
		else if (conv_done)
			temp_ff <= new_res;
	end

	// ----------------------------------------------------------------
	// Fault queue and alert
	// ----------------------------------------------------------------
	assign over_hit   = $signed(new_res) >= $signed(overtemp_limit_ff);
	assign under_hyst = $signed(new_res) < $signed(hysteresis_limit_ff);

	always_comb begin
		unique case ({cfg_ff.fault_count_bit_high, cfg_ff.fault_count_bit_low})
			2'b00:   fault_need = tsa_pkg::FQ_ONE;
			2'b01:   fault_need = tsa_pkg::FQ_TWO;
			2'b10:   fault_need = tsa_pkg::FQ_FOUR;
			default: fault_need = tsa_pkg::FQ_SIX;
		endcase
	end

	// Consecutive over-limit results; saturates at the deepest queue
	always_ff @(posedge clk_in) begin
		if (srst_in)
			fault_cnt_ff <= '0;
		else if (conv_done) begin
			if (!over_hit)
				fault_cnt_ff <= '0;
			else if (fault_cnt_ff < tsa_pkg::FQ_SIX)
				fault_cnt_ff <= fault_cnt_ff + 3'h1;
		end
	end

	assign fault_hit = over_hit && (fault_cnt_ff + 3'h1) >= fault_need;
	assign set_int   = conv_done && fault_hit && armed_ff;

	// Alert only moves on a new result or a read, never on mode changes
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			alert_ff <= 1'b0;
			armed_ff <= 1'b1;
		end else if (cfg_ff.comparator_interrupt_select_bit) begin
			if (set_int)
				alert_ff <= 1'b1;
			else if (rd_ev)
				alert_ff <= 1'b0;
			if (set_int)
				armed_ff <= 1'b0;
			else if (conv_done && under_hyst)
				armed_ff <= 1'b1;
		end else if (conv_done) begin
			if (fault_hit)
				alert_ff <= 1'b1;
			else if (under_hyst)
				alert_ff <= 1'b0;
			armed_ff <= 1'b1;
		end
	end

	// Pin level follows polarity; inactive is high after reset
	always_ff @(posedge clk_in) begin
		if (srst_in)
			alert_pin_ff <= 1'b1;
		else
			alert_pin_ff <= cfg_ff.alert_polarity_bit ? alert_ff : ~alert_ff;
	end

	assign temp_alert_output_out = alert_pin_ff;

endmodule

/* tsa_pkg.sv */
package tsa_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ          = 100_000_000;
	localparam int CONV_PERIOD_MS  = 80;
	localparam int CONV_PERIOD_CYC = (CLK_HZ / 1000) * CONV_PERIOD_MS;

	// ----------------------------------------------------------------
	// Serial slave address and byte framing
	// ----------------------------------------------------------------
	localparam logic [6:0] SLAVE_ADDR_DEF = 7'h48;
	localparam logic [3:0] BIT_LAST       = 4'h7;
	localparam logic [3:0] BIT_ACK        = 4'h8;

	// ----------------------------------------------------------------
	// Register pointer codes
	// ----------------------------------------------------------------
	localparam int         PTR_W       = 3;
	localparam logic [2:0] PTR_TEMP    = 3'h0;
	localparam logic [2:0] PTR_CFG     = 3'h1;
	localparam logic [2:0] PTR_HYST    = 3'h2;
	localparam logic [2:0] PTR_OVER    = 3'h3;
	localparam logic [2:0] PTR_ONESHOT = 3'h4;

	// ----------------------------------------------------------------
	// Reset values and masks
	// ----------------------------------------------------------------
	localparam logic [15:0] TEMP_RST      = 16'h0000;
	localparam logic [7:0]  CFG_RST       = 8'h00;
	localparam logic [15:0] HYST_RST      = 16'h4b00;
	localparam logic [15:0] OVER_RST      = 16'h5000;
	localparam logic [7:0]  CFG_WR_MASK   = 8'hbf;
	localparam logic [7:0]  RD_PAD        = 8'h00;
	localparam int          ADC_W         = 12;
	localparam logic [3:0]  RES_PAD       = 4'h0;

	// ----------------------------------------------------------------
	// Fault queue depths
	// ----------------------------------------------------------------
	localparam logic [2:0] FQ_ONE  = 3'h1;
	localparam logic [2:0] FQ_TWO  = 3'h2;
	localparam logic [2:0] FQ_FOUR = 3'h4;
	localparam logic [2:0] FQ_SIX  = 3'h6;

	// ----------------------------------------------------------------
	// Synchroniser lanes
	// ----------------------------------------------------------------
	localparam int         SY_SCL = 0;
	localparam int         SY_SDA = 1;
	localparam int         SY_PTR = 2;
	localparam int         SY_WR  = 3;
	localparam int         SY_RD  = 4;
	localparam int         SY_N   = 5;
	localparam logic [4:0] SY_RST = 5'h03;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       alert_smbus_en;
		logic       reserved;
		logic       oneshot_mode;
		logic       fault_count_bit_high;
		logic       fault_count_bit_low;
		logic       alert_polarity_bit;
		logic       comparator_interrupt_select_bit;
		logic       shutdown;
	} tsa_cfg_t;

	typedef struct packed {
		logic       second;
		logic [7:0] data;
	} tsa_wbyte_t;

	typedef enum logic [1:0] {
		CV_IDLE = 2'b01,
		CV_BUSY = 2'b10
	} tsa_conv_st_t;

	typedef enum logic [4:0] {
		PH_ADDR = 5'b00001,
		PH_PTR  = 5'b00010,
		PH_WR   = 5'b00100,
		PH_RD   = 5'b01000,
		PH_IDLE = 5'b10000
	} tsa_phase_t;

endpackage

/* tsa_link.sv */
module tsa_link (
	input  wire logic              scl_in,
	input  wire logic              sda_in,
	input  wire logic              frame_rst_in,
	input  wire logic              link_rst_in,
	input  wire logic [6:0]        slave_addr_in,
	input  wire logic [15:0]       rd_word_in,
	output logic                   sda_drive_low_out,
	output logic [7:0]             ptr_byte_out,
	output logic                   ptr_tog_out,
	output tsa_pkg::tsa_wbyte_t    wr_byte_out,
	output logic                   wr_tog_out,
	output logic                   rd_tog_out
);

	logic [3:0]          cnt_ff;
	logic [7:0]          shift_ff;
	tsa_pkg::tsa_phase_t phase_ff;
	logic                second_ff;
	logic                ack_ff;
	logic [7:0]          byte_w;
	logic [7:0]          rd_byte;

	// ----------------------------------------------------------------
	// Byte assembly
	// ----------------------------------------------------------------
	// Byte completes on the rise of its eighth bit
	assign byte_w  = {shift_ff[6:0], sda_in};
	assign rd_byte = second_ff ? rd_word_in[7:0] : rd_word_in[15:8];

	// Bit counter and phase, cleared by every start or stop
	always_ff @(posedge scl_in or posedge frame_rst_in) begin
		if (frame_rst_in) begin
			cnt_ff    <= '0;
			shift_ff  <= '0;
			phase_ff  <= tsa_pkg::PH_ADDR;
			second_ff <= 1'b0;
			ack_ff    <= 1'b0;
		end else if (cnt_ff == tsa_pkg::BIT_ACK) begin
			cnt_ff <= '0;
			ack_ff <= 1'b0;
			// Own address acknowledge leaves the byte order alone, so the MSB goes first
			if (phase_ff == tsa_pkg::PH_RD && !ack_ff) begin
				second_ff <= ~second_ff;
				// Master not-acknowledge ends the read
				if (sda_in)
					phase_ff <= tsa_pkg::PH_IDLE;
			end
		end else begin
			shift_ff <= byte_w;
			cnt_ff   <= cnt_ff + 4'h1;
			if (cnt_ff == tsa_pkg::BIT_LAST) begin
				unique case (phase_ff)
					tsa_pkg::PH_ADDR: begin
						if (byte_w[7:1] == slave_addr_in) begin
							ack_ff   <= 1'b1;
							phase_ff <= byte_w[0] ? tsa_pkg::PH_RD : tsa_pkg::PH_PTR;
						end else begin
							phase_ff <= tsa_pkg::PH_IDLE;
						end
					end
					tsa_pkg::PH_PTR: begin
						ack_ff   <= 1'b1;
						phase_ff <= tsa_pkg::PH_WR;
					end
					tsa_pkg::PH_WR: begin
						ack_ff    <= 1'b1;
						second_ff <= ~second_ff;
					end
					tsa_pkg::PH_RD, tsa_pkg::PH_IDLE: begin
					end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Events toward the core
	// ----------------------------------------------------------------
	// Toggles survive frame resets so no false event is seen across
	always_ff @(posedge scl_in or posedge link_rst_in) begin
		if (link_rst_in) begin
			ptr_byte_out <= '0;
			ptr_tog_out  <= 1'b0;
			wr_byte_out  <= '0;
			wr_tog_out   <= 1'b0;
			rd_tog_out   <= 1'b0;
		end else if (!frame_rst_in && cnt_ff == tsa_pkg::BIT_LAST) begin
			if (phase_ff == tsa_pkg::PH_PTR) begin
				ptr_byte_out <= byte_w;
				ptr_tog_out  <= ~ptr_tog_out;
			end
			if (phase_ff == tsa_pkg::PH_WR) begin
				wr_byte_out <= '{second: second_ff, data: byte_w};
				wr_tog_out  <= ~wr_tog_out;
			end
			// Snapshot request; a full bit period passes before data is shifted
			if (phase_ff == tsa_pkg::PH_ADDR && byte_w[7:1] == slave_addr_in && byte_w[0])
				rd_tog_out <= ~rd_tog_out;
		end
	end

	// ----------------------------------------------------------------
	// Data line drive
	// ----------------------------------------------------------------
	// Changes only while the clock is low; ~cnt picks bits MSB first
	always_ff @(negedge scl_in or posedge frame_rst_in) begin
		if (frame_rst_in)
			sda_drive_low_out <= 1'b0;
		else if (cnt_ff == tsa_pkg::BIT_ACK)
			sda_drive_low_out <= ack_ff;
		else if (phase_ff == tsa_pkg::PH_RD)
			sda_drive_low_out <= ~rd_byte[~cnt_ff[2:0]];
		else
			sda_drive_low_out <= 1'b0;
	end

endmodule

/* tsa_core_sva.sv */
module tsa_core_sva #(
	parameter int P = 200
) (
	input  wire logic clk_in,
	input  wire logic srst_in,
	input  wire logic scl_in,
	input  wire logic adc_done_in,
	input  wire logic sda_out,
	input  wire logic sda_oe_n_out,
	input  wire logic adc_start_out,
	input  wire logic adc_power_out,
	input  wire logic temp_alert_output_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	int   gap_ff = 0;
	int   hi_ff  = 0;
	logic pw_ff  = 1'b0;
	// ----
	// Helpers
	// ----
	// Gap restarts on wake too, so the first periodic start after leaving sleep is not seen as late
	always_ff @(posedge clk_in) begin
		pw_ff  <= adc_power_out;
		gap_ff <= (srst_in || adc_start_out || (adc_power_out && !pw_ff)) ? 0 : gap_ff + 1;
		hi_ff  <= scl_in ? hi_ff + 1 : 0;
	end
	sequence s_held;
		adc_power_out [*8];
	endsequence
	// ----
	// Properties
	// ----
	a_start_pulse: assert property (adc_start_out |=> !adc_start_out)
		else $error("start not a pulse");
	a_start_powered: assert property (adc_start_out |-> adc_power_out ##1 s_held)
		else $error("converter unpowered");
	a_period_max: assert property (adc_power_out && pw_ff |-> gap_ff <= P + 2)
		else $error("periodic start missing");
	a_drive_on_low: assert property ($fell(sda_oe_n_out) |-> !scl_in)
		else $error("sda driven while scl high");
	a_idle_release: assert property (hi_ff > 300 |-> sda_oe_n_out)
		else $error("sda held at idle");
	a_sda_zero: assert property (sda_out == 1'b0)
		else $error("sda driven high");
	a_alert_cause: assert property ($changed(temp_alert_output_out) && hi_ff > 300
		|-> $past(adc_done_in, 2) || $past(adc_done_in, 3))
		else $error("alert moved without result");
	a_reset_quiet: assert property (disable iff (1'b0) srst_in
		|=> sda_oe_n_out && !adc_start_out && !adc_power_out && temp_alert_output_out)
		else $error("outputs active in reset");
endmodule

bind tsa_core tsa_core_sva #(.P(CONV_PERIOD_CYC_P)) u_sva (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in),
	.adc_done_in(adc_done_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .adc_start_out(adc_start_out),
	.adc_power_out(adc_power_out), .temp_alert_output_out(temp_alert_output_out));

/* tsa_master.sv */
module tsa_master (
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_low_out
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ADDR_W = {tsa_pkg::SLAVE_ADDR_DEF, 1'b0};
	// ----
	// Bus phases
	// ----
	// Clock parks high between frames
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	// Data moves only while scl is low
	task automatic bit_x(input logic b, output logic r);
		sda_low_out = !b;
		#300 scl_out = 1'b1;
		#300 r = sda_in;
		#300 scl_out = 1'b0;
		#300;
	endtask
	// Releases sda first so a repeated start can fall with scl high
	task automatic start;
		sda_low_out = 1'b0;
		#300 scl_out = 1'b1;
		#600 sda_low_out = 1'b1;
		#600 scl_out = 1'b0;
		#300;
	endtask
	task automatic stop;
		sda_low_out = 1'b1;
		#300 scl_out = 1'b1;
		#600 sda_low_out = 1'b0;
		#1300;
	endtask
	task automatic put(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_x(d[i], r);
		bit_x(1'b1, r);
	endtask
	task automatic get(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(last, r);
	endtask
	// Pointer, then n data bytes MSB first
	task automatic wr(input logic [2:0] p, input logic [15:0] d, input int n);
		start;
		put(ADDR_W);
		put({5'h00, p});
		if (n > 0) put(d[15:8]);
		if (n > 1) put(d[7:0]);
		stop;
	endtask
	// Optional pointer write, then a two-byte read ended by a NACK
	task automatic rd(input logic setp, input logic [2:0] p, output logic [15:0] d);
		if (setp) begin
			start;
			put(ADDR_W);
			put({5'h00, p});
		end
		start;
		put(ADDR_W | 8'h01);
		get(1'b0, d[15:8]);
		get(1'b1, d[7:0]);
		stop;
	endtask
endmodule

/* tsa_core_bench.sv */
module tsa_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int P = 200;
	logic        clk_in = 1'b0;
	logic        srst_in = 1'b1;
	logic        adc_done_in = 1'b0;
	logic [11:0] adc_data_in = 12'h000;
	logic [11:0] adc_val = 12'h000;
	logic        sda_out, sda_oe_n_out, adc_start_out, adc_power_out, temp_alert_output_out, scl, m_low;
	logic [15:0] rv;
	int          n_fail = 0, num_checks = 0, n_st = 0, ad = 0;
	wire logic   sda_in = !m_low && sda_oe_n_out; // Pull-up wire
	tsa_master M (.sda_in(sda_in), .scl_out(scl), .sda_low_out(m_low));
	tsa_core #(.CONV_PERIOD_CYC_P(P)) DUT (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl), .sda_in(sda_in),
		.adc_done_in(adc_done_in), .adc_data_in(adc_data_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
		.adc_start_out(adc_start_out), .adc_power_out(adc_power_out), .temp_alert_output_out(temp_alert_output_out));
	// ----
	// Clock and converter stand-in
	// ----
	initial begin
		forever #5 clk_in = !clk_in;
	end
	// Twenty cycles per conversion, well inside the period
	always @(posedge clk_in) begin
		adc_done_in <= (ad == 1);
		adc_data_in <= adc_val;
		if (adc_start_out) ad <= 20;
		else if (ad > 0) ad <= ad - 1;
		if (adc_start_out) n_st <= n_st + 1;
	end
	// ----
	// Tasks
	// ----
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic rchk(input logic [2:0] p, input logic [15:0] exp);
		M.rd(1'b1, p, rv);
		chk("register", exp, rv);
	endtask
	task automatic shot(input logic [11:0] v);
		adc_val = v;
		M.wr(3'h4, 16'h5a00, 1);
		cyc(60);
	endtask
	task automatic t_reset;
		M.rd(1'b0, 3'h0, rv);
		chk("temperature", tsa_pkg::TEMP_RST, rv);
		rchk(3'h3, tsa_pkg::OVER_RST);
		chk("alert", 16'h0001, {15'h0000, temp_alert_output_out});
		$display("reset test done");
	endtask
	task automatic t_conv;
		int s;
		adc_val = 12'h500;
		cyc(P + 40);
		s = n_st;
		cyc(5 * P);
		chk("starts", 16'h0005, 16'(n_st - s));
		chk("alert", 16'h0000, {15'h0000, temp_alert_output_out});
		rchk(3'h0, 16'h5000);
		adc_val = 12'h4a0;
		cyc(P + 40);
		chk("alert", 16'h0001, {15'h0000, temp_alert_output_out});
		$display("conversion test done");
	endtask
	task automatic t_shut;
		int s;
		M.wr(3'h1, 16'h0100, 1);
		adc_val = 12'h123;
		s = n_st;
		cyc(3 * P);
		chk("starts", 16'h0000, 16'(n_st - s));
		rchk(3'h0, 16'h4a00);
		shot(12'h123);
		chk("starts", 16'h0001, 16'(n_st - s));
		chk("power", 16'h0000, {15'h0000, adc_power_out});
		rchk(3'h1, 16'h0100);
		rchk(3'h0, 16'h1230);
		$display("shutdown test done");
	endtask
	task automatic t_int;
		M.wr(3'h1, 16'h0700, 1);
		chk("alert", 16'h0000, {15'h0000, temp_alert_output_out});
		shot(12'h500);
		chk("alert", 16'h0001, {15'h0000, temp_alert_output_out});
		rchk(3'h0, 16'h5000);
		chk("alert", 16'h0000, {15'h0000, temp_alert_output_out});
		shot(12'h510);
		chk("alert", 16'h0000, {15'h0000, temp_alert_output_out});
		$display("interrupt test done");
	endtask
	// Two faults needed: one over-limit result must not trip the pin
	task automatic t_fault;
		M.wr(3'h1, 16'h0900, 1);
		chk("alert", 16'h0001, {15'h0000, temp_alert_output_out});
		shot(12'h123);
		shot(12'h500);
		chk("alert", 16'h0001, {15'h0000, temp_alert_output_out});
		shot(12'h500);
		chk("alert", 16'h0000, {15'h0000, temp_alert_output_out});
		$display("fault queue test done");
	endtask
	task automatic wrap_up;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// ----
	// Sequence and watchdog
	// ----
	initial begin
		repeat (3) @(posedge clk_in);
		srst_in <= 1'b0;
		cyc(10);
		t_reset();
		t_conv();
		t_shut();
		t_int();
		t_fault();
		wrap_up();
	end
	// Tests need about 0.75 ms of bus traffic; later than this means a hang
	initial begin
		#950us;
		n_fail++;
		wrap_up();
	end
endmodule
